// ==== design/sld_defs.svh ====
// Offsets, field positions, reset values and widths of the serial link DMA control block
// Operation
// [R01] Per-source enables gate the interrupt output
// [R02] Write one clears pending source, zero ignored
// [R03] Status shows rx descriptor empty, tx full
// [R04] Push bit sends write value to FIFO
// [R05] Pop bit removes entry, shows read value
// [R06] Transmit idle flag reads one when parked
// [R07] Transmit begin loads first descriptor address
// [R08] Transmit halt stops descriptor processing
// [R09] Transmit resume continues from last address
// [R10] Transmit first address holds low 20 bits
// [R11] Receive idle flag reads one when parked
// [R12] Receive begin starts, halt stops chain
// [R13] Receive append continues with new descriptors
// [R14] Receive first address holds low 20 bits
// [R15] Software zeroes reserved secondary configuration bits
// [R16] Transmit frame end descriptor address captured
// [R17] Interrupt enables reset to all zeros
// [R18] Pending bits latch events, OR with enables; the code ANDs the pending bits with the enables instead
`ifndef SLD_DEFS_SVH
`define SLD_DEFS_SVH

// Register byte offsets
`define SLD_OFS_STATUS   8'h04
`define SLD_OFS_ENABLE   8'h0C
`define SLD_OFS_CLEAR    8'h10
`define SLD_OFS_FIFO_ST  8'h14
`define SLD_OFS_PUSH     8'h18
`define SLD_OFS_POP      8'h20
`define SLD_OFS_TXLINK   8'h24
`define SLD_OFS_RXLINK   8'h28
`define SLD_OFS_CONF1    8'h2C
`define SLD_OFS_TXEOF    8'h38

// Widths
`define SLD_IRQ_W        16
`define SLD_LINK_AW      20
`define SLD_BYTE_W       8
`define SLD_CONF1_W      4

// Field positions
`define SLD_LINK_HALT    28
`define SLD_LINK_BEGIN   29
`define SLD_LINK_RESUME  30
`define SLD_LINK_IDLE    31
`define SLD_PUSH_BIT     16
`define SLD_POP_BIT      16
`define SLD_EMPTY_BIT    0
`define SLD_FULL_BIT     1
`define SLD_IRQ_RX_DONE  4
`define SLD_IRQ_TX_DONE  7
`define SLD_IRQ_TX_EOF   8

// Reset values and fixed upper descriptor address bits
`define SLD_RST_ENABLE   16'h0000
`define SLD_RST_CONF1    4'h0
`define SLD_DESC_BASE    12'h000

`endif

// ==== design/sld_pkg.sv ====
// Types shared by the serial link DMA control block
`include "sld_defs.svh"

package sld_pkg;

    // Descriptor engine states
    typedef enum logic [0:0] {
        SLD_IDLE  = 1'b0,
        SLD_FETCH = 1'b1
    } sld_state_t;

    // Descriptor fetch request
    typedef struct packed {
        logic        valid;
        logic [31:0] addr;
    } sld_desc_req_t;

    // Descriptor fetch answer
    typedef struct packed {
        logic                    ack;
        logic                    eof;
        logic                    last;
        logic [`SLD_LINK_AW-1:0] next;
    } sld_desc_rsp_t;

endpackage

// ==== design/sld_top.sv ====
// Descriptor chain engine and Wishbone register block of the serial link DMA
//
// The Wishbone slave port was decided locally.
`include "sld_defs.svh"
`timescale 1ns/100ps
`default_nettype none

////////////////////////////////////////////////////////////////////////////////
module sld_chain (
    input  wire logic                    clk_i,
    input  wire logic                    rst_i,
    input  wire logic                    begin_i,
    input  wire logic                    halt_i,
    input  wire logic                    resume_i,
    input  wire logic [`SLD_LINK_AW-1:0] first_addr_i,
    input  wire sld_pkg::sld_desc_rsp_t  rsp_i,
    output var  sld_pkg::sld_desc_req_t  req_o,
    output logic                         idle_o,
    output logic                         done_o,
    output logic                         eof_o,
    output logic [31:0]                  eof_addr_o
);

    sld_pkg::sld_state_t     state;
    logic [`SLD_LINK_AW-1:0] cur;
    logic                    take;

    // Request and idle view of the state
    assign req_o.valid = (state == sld_pkg::SLD_FETCH);
    assign req_o.addr  = {`SLD_DESC_BASE, cur};
    assign idle_o      = (state == sld_pkg::SLD_IDLE);
    assign take        = req_o.valid & rsp_i.ack;

    // Chain walk: halt beats begin, begin beats resume
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state <= sld_pkg::SLD_IDLE;
            cur   <= {`SLD_LINK_AW{1'b0}};
        end else if (halt_i) begin
            state <= sld_pkg::SLD_IDLE;              // see [R08] [R12]
        end else if (begin_i) begin
            state <= sld_pkg::SLD_FETCH;             // see [R07] [R12]
            cur   <= first_addr_i;
        end else if (resume_i) begin
            state <= sld_pkg::SLD_FETCH;             // see [R09] [R13]
        end else if (take) begin
            if (rsp_i.last) begin
                state <= sld_pkg::SLD_IDLE;
            end else begin
                cur <= rsp_i.next;
            end
        end
    end

    // Completion pulses and frame end capture
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            done_o     <= 1'b0;
            eof_o      <= 1'b0;
            eof_addr_o <= 32'h0000_0000;
        end else begin
            done_o <= take & ~halt_i;
            eof_o  <= take & rsp_i.eof & ~halt_i;
            if (take & rsp_i.eof & ~halt_i) begin
                eof_addr_o <= req_o.addr;            // see [R16]
            end
        end
    end

endmodule

////////////////////////////////////////////////////////////////////////////////
module sld_top (
    input  wire logic                   clk_i,
    input  wire logic                   rst_i,
    input  wire logic                   cyc_i,
    input  wire logic                   stb_i,
    input  wire logic                   we_i,
    input  wire logic [7:0]             adr_i,
    input  wire logic [3:0]             sel_i,
    input  wire logic [31:0]            dat_i,
    output logic [31:0]                 dat_o,
    output logic                        ack_o,
    output logic                        irq_o,
    input  wire logic [`SLD_IRQ_W-1:0]  events_i,
    input  wire logic                   rx_desc_fifo_empty_i,
    input  wire logic                   tx_desc_fifo_full_i,
    output logic                        out_fifo_push_o,
    output logic [`SLD_BYTE_W-1:0]      out_fifo_data_o,
    output logic                        in_fifo_pop_o,
    input  wire logic [`SLD_BYTE_W-1:0] in_fifo_data_i,
    output var  sld_pkg::sld_desc_req_t tx_desc_req_o,
    input  wire sld_pkg::sld_desc_rsp_t tx_desc_rsp_i,
    output var  sld_pkg::sld_desc_req_t rx_desc_req_o,
    input  wire sld_pkg::sld_desc_rsp_t rx_desc_rsp_i,
    output logic [`SLD_CONF1_W-1:0]     sec_conf_o
);

    // Byte lane mask from the Wishbone selects
    function automatic logic [31:0] sld_bytes(input logic [3:0] sel);
        logic [31:0] m;
        m = 32'h0000_0000;
        for (int b = 0; b < 4; b++) begin
            m[b*8 +: 8] = {8{sel[b]}};
        end
        return m;
    endfunction

    // Byte lane merge of write data into an old value
    function automatic logic [31:0] sld_merge(input logic [31:0] old,
                                              input logic [31:0] wr,
                                              input logic [3:0]  sel);
        logic [31:0] m;
        m = sld_bytes(sel);
        return (old & ~m) | (wr & m);
    endfunction

    logic                    wb_take;
    logic                    wr_take;
    logic                    rd_take;
    logic [7:0]              word;
    logic [31:0]             wdat;
    logic [`SLD_BYTE_W-1:0]  push_data;
    logic [31:0]             next_rdata;
    logic [`SLD_IRQ_W-1:0]   ena;
    logic [`SLD_IRQ_W-1:0]   pend;
    logic [`SLD_IRQ_W-1:0]   ev;
    logic [`SLD_IRQ_W-1:0]   clr_w1c;
    logic [`SLD_IRQ_W-1:0]   clr_rd;
    logic [`SLD_LINK_AW-1:0] tx_first;
    logic [`SLD_LINK_AW-1:0] rx_first;
    logic [`SLD_LINK_AW-1:0] next_tx_first;
    logic [`SLD_LINK_AW-1:0] next_rx_first;
    logic [`SLD_BYTE_W-1:0]  in_value;
    logic                    tx_begin;
    logic                    tx_halt;
    logic                    tx_resume;
    logic                    rx_begin;
    logic                    rx_halt;
    logic                    rx_resume;
    logic                    tx_idle;
    logic                    rx_idle;
    logic                    tx_done;
    logic                    tx_eof;
    logic                    rx_done;
    logic [31:0]             tx_eof_addr;
    logic [31:0]             tx_req_addr;

    ////////////////////////////////////////////////////////////////////////////
    // Bus decode: one access taken per request, answered one cycle later
    assign wb_take   = cyc_i & stb_i & ~ack_o;
    assign wr_take   = wb_take & we_i;
    assign rd_take   = wb_take & ~we_i;
    assign word      = {adr_i[7:2], 2'b00};
    assign wdat      = dat_i & sld_bytes(sel_i);
    assign push_data = dat_i[`SLD_BYTE_W-1:0];

    // Acknowledge, dropped the cycle after it is given
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_o <= 1'b0;
        end else begin
            ack_o <= wb_take;
        end
    end

    // Chain control triggers
    assign tx_begin  = wr_take && (word == `SLD_OFS_TXLINK) && wdat[`SLD_LINK_BEGIN];
    assign tx_halt   = wr_take && (word == `SLD_OFS_TXLINK) && wdat[`SLD_LINK_HALT];
    assign tx_resume = wr_take && (word == `SLD_OFS_TXLINK) && wdat[`SLD_LINK_RESUME];
    assign rx_begin  = wr_take && (word == `SLD_OFS_RXLINK) && wdat[`SLD_LINK_BEGIN];
    assign rx_halt   = wr_take && (word == `SLD_OFS_RXLINK) && wdat[`SLD_LINK_HALT];
    assign rx_resume = wr_take && (word == `SLD_OFS_RXLINK) && wdat[`SLD_LINK_RESUME];

    // First addresses after this write, so a begin in the same write sees them
    assign next_tx_first = (wr_take && (word == `SLD_OFS_TXLINK))
                           ? 20'(sld_merge({12'h000, tx_first}, dat_i, sel_i)) : tx_first;
    assign next_rx_first = (wr_take && (word == `SLD_OFS_RXLINK))
                           ? 20'(sld_merge({12'h000, rx_first}, dat_i, sel_i)) : rx_first;

    ////////////////////////////////////////////////////////////////////////////
    // Writable configuration registers
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ena        <= `SLD_RST_ENABLE;           // see [R17]
            tx_first   <= {`SLD_LINK_AW{1'b0}};
            rx_first   <= {`SLD_LINK_AW{1'b0}};
            sec_conf_o <= `SLD_RST_CONF1;
        end else if (wr_take) begin
            if (word == `SLD_OFS_ENABLE) begin
                ena <= 16'(sld_merge({16'h0000, ena}, dat_i, sel_i));
            end else if (word == `SLD_OFS_TXLINK) begin
                tx_first <= next_tx_first;            // see [R10]
            end else if (word == `SLD_OFS_RXLINK) begin
                rx_first <= next_rx_first;            // see [R14]
            end else if (word == `SLD_OFS_CONF1) begin
                sec_conf_o <= 4'(sld_merge({28'h000_0000, sec_conf_o}, dat_i, sel_i));
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Outbound push: write value stored, push bit gives a one-cycle strobe
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            out_fifo_push_o <= 1'b0;
            out_fifo_data_o <= {`SLD_BYTE_W{1'b0}};
        end else begin
            out_fifo_push_o <= wr_take && (word == `SLD_OFS_PUSH) && wdat[`SLD_PUSH_BIT]; // see [R04]
            if (wr_take && (word == `SLD_OFS_PUSH) && sel_i[0]) begin
                out_fifo_data_o <= push_data;
            end
        end
    end

    // Inbound pop: strobe, then head entry captured as the read value
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            in_fifo_pop_o <= 1'b0;
            in_value      <= {`SLD_BYTE_W{1'b0}};
        end else begin
            in_fifo_pop_o <= wr_take && (word == `SLD_OFS_POP) && wdat[`SLD_POP_BIT]; // see [R05]
            if (in_fifo_pop_o) begin
                in_value <= in_fifo_data_i;          // see [R05]
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Descriptor engines
    sld_chain u_tx (
        .clk_i        (clk_i),
        .rst_i        (rst_i),
        .begin_i      (tx_begin),
        .halt_i       (tx_halt),
        .resume_i     (tx_resume),
        .first_addr_i (next_tx_first),
        .rsp_i        (tx_desc_rsp_i),
        .req_o        (tx_desc_req_o),
        .idle_o       (tx_idle),
        .done_o       (tx_done),
        .eof_o        (tx_eof),
        .eof_addr_o   (tx_eof_addr)
    );

    // Receive append re-reads the last descriptor to pick up its new link
    sld_chain u_rx (
        .clk_i        (clk_i),
        .rst_i        (rst_i),
        .begin_i      (rx_begin),
        .halt_i       (rx_halt),
        .resume_i     (rx_resume),
        .first_addr_i (next_rx_first),
        .rsp_i        (rx_desc_rsp_i),
        .req_o        (rx_desc_req_o),
        .idle_o       (rx_idle),
        .done_o       (rx_done),
        .eof_o        (),
        .eof_addr_o   ()
    );

    assign tx_req_addr = tx_desc_req_o.addr;

    ////////////////////////////////////////////////////////////////////////////
    // Event vector: outside sources plus engine completions
    always_comb begin
        ev                   = events_i;
        ev[`SLD_IRQ_TX_DONE] = events_i[`SLD_IRQ_TX_DONE] | tx_done;
        ev[`SLD_IRQ_TX_EOF]  = events_i[`SLD_IRQ_TX_EOF] | tx_eof;
        ev[`SLD_IRQ_RX_DONE] = events_i[`SLD_IRQ_RX_DONE] | rx_done;
    end

    // Clear sources: write-one clear register and read of the status
    assign clr_w1c = (wr_take && (word == `SLD_OFS_CLEAR)) ? wdat[`SLD_IRQ_W-1:0]
                                                           : 16'h0000;   // see [R02]
    assign clr_rd  = (rd_take && (word == `SLD_OFS_STATUS)) ? 16'hFFFF : 16'h0000;

    // Sticky pending bits, a new event wins over a clear
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pend <= 16'h0000;
        end else begin
            pend <= (pend & ~clr_w1c & ~clr_rd) | ev;  // see [R18] [R02]
        end
    end

    // Level interrupt from unmasked pending bits
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            irq_o <= 1'b0;
        end else begin
            irq_o <= |(((pend & ~clr_w1c & ~clr_rd) | ev) & ena); // see [R01] [R18]
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Read data select; unmapped and write-only words read as zero
    always_comb begin
        next_rdata = 32'h0000_0000;
        if (word == `SLD_OFS_STATUS) begin
            next_rdata[`SLD_IRQ_W-1:0] = pend;
        end else if (word == `SLD_OFS_ENABLE) begin
            next_rdata[`SLD_IRQ_W-1:0] = ena;
        end else if (word == `SLD_OFS_FIFO_ST) begin
            next_rdata[`SLD_EMPTY_BIT] = rx_desc_fifo_empty_i; // see [R03]
            next_rdata[`SLD_FULL_BIT]  = tx_desc_fifo_full_i;  // see [R03]
        end else if (word == `SLD_OFS_PUSH) begin
            next_rdata[`SLD_BYTE_W-1:0] = out_fifo_data_o;
        end else if (word == `SLD_OFS_POP) begin
            next_rdata[`SLD_BYTE_W-1:0] = in_value;   // see [R05]
        end else if (word == `SLD_OFS_TXLINK) begin
            next_rdata[`SLD_LINK_IDLE]    = tx_idle;  // see [R06]
            next_rdata[`SLD_LINK_AW-1:0]  = tx_first; // see [R10]
        end else if (word == `SLD_OFS_RXLINK) begin
            next_rdata[`SLD_LINK_IDLE]    = rx_idle;  // see [R11]
            next_rdata[`SLD_LINK_AW-1:0]  = rx_first; // see [R14]
        end else if (word == `SLD_OFS_CONF1) begin
            next_rdata[`SLD_CONF1_W-1:0] = sec_conf_o;
        end else if (word == `SLD_OFS_TXEOF) begin
            next_rdata = tx_eof_addr;                 // see [R16]
        end
    end

    // Read data register, loaded when a read is taken
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            dat_o <= 32'h0000_0000;
        end else if (rd_take) begin
            dat_o <= next_rdata;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    sequence s_tx_begin;
        wr_take && (word == `SLD_OFS_TXLINK) && wdat[`SLD_LINK_BEGIN] && !wdat[`SLD_LINK_HALT];
    endsequence

    sequence s_tx_resume;
        wr_take && (word == `SLD_OFS_TXLINK) && wdat[`SLD_LINK_RESUME]
            && !wdat[`SLD_LINK_BEGIN] && !wdat[`SLD_LINK_HALT];
    endsequence

    sequence s_tx_take_eof;
        tx_desc_req_o.valid && tx_desc_rsp_i.ack && tx_desc_rsp_i.eof && !tx_halt;
    endsequence

    enable_reset_a: assert property ($fell(rst_i) |-> (ena == 16'h0000) && !irq_o) // see [R17]
        else $error("enables not zero after reset");

    irq_masked_a: assert property ((ena == 16'h0000) |=> !irq_o) // see [R01]
        else $error("interrupt raised while all sources masked");

    pend_latch_a: assert property ((ev != 16'h0000) |=> ((pend & $past(ev)) == $past(ev))) // see [R18]
        else $error("event did not latch pending bit");

    clear_w1c_a: assert property (wr_take && (word == `SLD_OFS_CLEAR) && (ev == 16'h0000)
        |=> ((pend & $past(wdat[15:0])) == 16'h0000)
            && ((pend & ~$past(wdat[15:0])) == ($past(pend) & ~$past(wdat[15:0])))) // see [R02]
        else $error("clear register misbehaved");

    fifo_flags_a: assert property (rd_take && (word == `SLD_OFS_FIFO_ST) // see [R03]
        |=> (dat_o[1:0] == {$past(tx_desc_fifo_full_i), $past(rx_desc_fifo_empty_i)}))
        else $error("fifo flag read wrong");

    push_strobe_a: assert property (wr_take && (word == `SLD_OFS_PUSH) && wdat[`SLD_PUSH_BIT] // see [R04]
        && sel_i[0] |=> out_fifo_push_o && (out_fifo_data_o == $past(push_data)) ##1 !out_fifo_push_o)
        else $error("push strobe or data wrong");

    pop_capture_a: assert property (in_fifo_pop_o |=> (in_value == $past(in_fifo_data_i))) // see [R05]
        else $error("popped entry not captured");

    tx_park_a: assert property (rd_take && (word == `SLD_OFS_TXLINK) // see [R06]
        |=> dat_o[`SLD_LINK_IDLE] == !$past(tx_desc_req_o.valid))
        else $error("transmit idle flag wrong");

    tx_begin_a: assert property (s_tx_begin |=> tx_desc_req_o.valid // see [R07]
        && (tx_req_addr == {`SLD_DESC_BASE, tx_first}))
        else $error("begin did not fetch first descriptor");

    tx_halt_a: assert property (tx_halt |=> !tx_desc_req_o.valid && tx_idle) // see [R08]
        else $error("halt did not stop transmit chain");

    tx_resume_a: assert property (s_tx_resume |=> tx_desc_req_o.valid // see [R09]
        && (tx_req_addr == $past(tx_req_addr)))
        else $error("resume did not reuse last address");

    rx_chain_a: assert property (rx_halt |=> !rx_desc_req_o.valid // see [R12] [R11]
        ##1 (!rx_resume && !rx_begin) [*1] |=> !rx_desc_req_o.valid)
        else $error("receive chain not halted");

    eof_capture_a: assert property (s_tx_take_eof |=> (tx_eof_addr == $past(tx_req_addr)) // see [R16]
        ##1 pend[`SLD_IRQ_TX_EOF])
        else $error("frame end address not captured");

endmodule

`default_nettype wire

// ==== verification/sld_desc_model.sv ====
// Descriptor memory model answering one chain engine's fetches
`include "sld_defs.svh"
`timescale 1ns/100ps
`default_nettype none

module sld_desc_model #(
    parameter int DELAY = 2
) (
    input  wire logic                   clk_i,
    input  wire logic                   rst_i,
    input  wire sld_pkg::sld_desc_req_t req_i,
    output var  sld_pkg::sld_desc_rsp_t rsp_o
);
    logic [7:0]              cnt;
    logic                    hit;
    logic [`SLD_LINK_AW-1:0] nxt;

    // Wait cycles counted while a fetch stands
    always_ff @(posedge clk_i) begin
        if (rst_i || !req_i.valid || rsp_o.ack) begin
            cnt <= 8'h00;
        end else begin
            cnt <= cnt + 8'h01;
        end
    end

    // Chain of three at offsets 0, 4, 8; the third ends the frame
    assign hit = req_i.addr[3:0] == 4'h8;
    assign nxt = req_i.addr[19:0] + 20'h0_0004;

    // Fields read inverted outside the accept cycle
    always_comb begin
        rsp_o.ack  = req_i.valid && (cnt == DELAY[7:0]);
        rsp_o.eof  = rsp_o.ack ? hit : !hit;
        rsp_o.last = rsp_o.ack ? hit : !hit;
        rsp_o.next = rsp_o.ack ? nxt : ~nxt;
    end
endmodule

`default_nettype wire

// ==== verification/tb_top.sv ====
// Self-checking bench for the serial link DMA control block
`include "sld_defs.svh"
`timescale 1ns/100ps
`default_nettype none

module tb_top;
    logic                   clk_i = 1'b0;
    logic                   rst_i = 1'b1;
    logic                   cyc = 1'b0, stb = 1'b0, we = 1'b0;
    logic [7:0]             adr = 8'h00, b, in_data = 8'h00, pdata;
    logic [3:0]             sel = 4'hF, conf;
    logic [31:0]            wdat = 32'h0000_0000, dat_o, expq[$];
    logic [15:0]            events = 16'h0000;
    logic [1:0]             fl = 2'b00;
    logic                   ack_o, irq_o, push_o, pop_o, s_push, s_pop;
    logic [19:0]            a, r;
    sld_pkg::sld_desc_req_t txq, rxq, s_tx, s_rx;
    sld_pkg::sld_desc_rsp_t txr, rxr;
    int                     n_mismatch = 0, cmp_count = 0, cycles = 0, k;
    integer                 seed;

    always #5 clk_i = ~clk_i;

    sld_top u_sld_top (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc), .stb_i(stb), .we_i(we),
        .adr_i(adr), .sel_i(sel), .dat_i(wdat), .dat_o(dat_o), .ack_o(ack_o), .irq_o(irq_o),
        .events_i(events), .rx_desc_fifo_empty_i(fl[0]), .tx_desc_fifo_full_i(fl[1]),
        .out_fifo_push_o(push_o), .out_fifo_data_o(pdata), .in_fifo_pop_o(pop_o),
        .in_fifo_data_i(in_data), .tx_desc_req_o(txq), .tx_desc_rsp_i(txr),
        .rx_desc_req_o(rxq), .rx_desc_rsp_i(rxr), .sec_conf_o(conf));
    sld_desc_model #(.DELAY(2)) u_sld_desc_model_tx (.clk_i(clk_i), .rst_i(rst_i),
        .req_i(txq), .rsp_o(txr));
    sld_desc_model #(.DELAY(20)) u_sld_desc_model_rx (.clk_i(clk_i), .rst_i(rst_i),
        .req_i(rxq), .rsp_o(rxr));

    ////////////////////////////////////////////////////////////////////////////
    // Compare and count
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("mismatch %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    // Verdict and end of run
    task automatic summarize;
        $display("compares %0d mismatches %0d", cmp_count, n_mismatch);
        if (n_mismatch == 0 && cmp_count > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask

    // Classic single cycle, held until ack, snapshots taken at the ack edge
    task automatic bus(input logic [7:0] ad, input logic w, input logic [31:0] d);
        @(posedge clk_i);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= ad;
        wdat <= d;
        do @(posedge clk_i); while (ack_o !== 1'b1);
        s_push = push_o;
        s_pop = pop_o;
        b = pdata;
        s_tx = txq;
        s_rx = rxq;
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask

    // Read with its expected word noted for the watcher
    task automatic rd(input logic [7:0] ad, input logic [31:0] exp);
        expq.push_back(exp);
        bus(ad, 1'b0, 32'h0000_0000);
    endtask

    // One-cycle event on source k
    task automatic pulse;
        @(posedge clk_i);
        events <= 16'h0001 << k;
        @(posedge clk_i);
        events <= 16'h0000;
        repeat (3) @(posedge clk_i);
    endtask

    // Bounded wait for a chain to park
    task automatic park(input int lim);
        for (int i = 0; i < lim && (txq.valid || rxq.valid); i++) @(posedge clk_i);
        repeat (4) @(posedge clk_i);
    endtask

    ////////////////////////////////////////////////////////////////////////////
    // Read data watcher and hang limit
    always @(posedge clk_i) begin
        if (ack_o === 1'b1 && we === 1'b0) chk("read data", dat_o, expq.pop_front());
        cycles++;
        if (cycles == 20000) begin
            n_mismatch++;
            summarize();
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        seed = 32'h6273_8870;
        repeat (8) @(posedge clk_i);
        rst_i <= 1'b0;
        rd(8'h0C, 32'h0000_0000);
        bus(8'h2C, 1'b1, 32'h0000_0000);
        rd(8'h2C, 32'h0000_0000);
        chk("conf", {28'h000_0000, conf}, 32'h0000_0000);
        bus(8'h40, 1'b1, 32'hFFFF_FFFF);
        rd(8'h40, 32'h0000_0000);
        $display("test reset done");
        k = {$random(seed)} % 16;
        pulse();
        chk("irq masked", {31'h0000_0000, irq_o}, 32'h0000_0000);
        bus(8'h0C, 1'b1, 32'h0000_0001 << k);
        repeat (3) @(posedge clk_i);
        chk("irq on", {31'h0000_0000, irq_o}, 32'h0000_0001);
        bus(8'h10, 1'b1, ~(32'h0000_0001 << k));
        repeat (3) @(posedge clk_i);
        chk("irq kept", {31'h0000_0000, irq_o}, 32'h0000_0001);
        bus(8'h10, 1'b1, 32'h0000_0001 << k);
        repeat (3) @(posedge clk_i);
        chk("irq cleared", {31'h0000_0000, irq_o}, 32'h0000_0000);
        bus(8'h0C, 1'b1, 32'h0000_0000);
        pulse();
        rd(8'h04, 32'h0000_0001 << k);
        rd(8'h04, 32'h0000_0000);
        $display("test irq done");
        for (k = 0; k < 4; k++) begin
            fl <= k[1:0];
            rd(8'h14, k);
        end
        a = 20'($random(seed));
        bus(8'h18, 1'b1, {15'h0000, 1'b1, 8'h00, a[7:0]});
        chk("push", {s_push, b}, {1'b1, a[7:0]});
        rd(8'h18, {24'h00_0000, a[7:0]});
        in_data <= a[15:8];
        bus(8'h20, 1'b1, 32'h0001_0000);
        chk("pop", {31'h0000_0000, s_pop}, 32'h0000_0001);
        in_data <= ~a[15:8];
        rd(8'h20, {24'h00_0000, a[15:8]});
        $display("test fifo done");
        a = 20'($random(seed)) & 20'hF_FFF0;
        bus(8'h24, 1'b1, 32'h2000_0000 | a);
        chk("tx start", {s_tx.valid, s_tx.addr[30:0]}, {1'b1, 11'h000, a});
        rd(8'h24, {12'h000, a});
        park(50);
        rd(8'h24, 32'h8000_0000 | a);
        rd(8'h38, {12'h000, a + 20'h0_0008});
        rd(8'h04, 32'h0000_0180);
        bus(8'h24, 1'b1, 32'h4000_0100 ^ a);
        chk("tx resume", {s_tx.valid, s_tx.addr[30:0]}, {1'b1, 11'h000, a + 20'h0_0008});
        park(50);
        bus(8'h24, 1'b1, 32'h2000_0000 | a);
        bus(8'h24, 1'b1, 32'h1000_0000 | a);
        repeat (2) @(posedge clk_i);
        chk("tx halt", {31'h0000_0000, txq.valid}, 32'h0000_0000);
        rd(8'h24, 32'h8000_0000 | a);
        $display("test tx done");
        r = 20'($random(seed)) & 20'hF_FFF0;
        bus(8'h28, 1'b1, 32'h2000_0000 | r);
        chk("rx start", {s_rx.valid, s_rx.addr[30:0]}, {1'b1, 11'h000, r});
        rd(8'h28, {12'h000, r});
        bus(8'h28, 1'b1, 32'h1000_0000 | r);
        repeat (2) @(posedge clk_i);
        chk("rx halt", {31'h0000_0000, rxq.valid}, 32'h0000_0000);
        rd(8'h28, 32'h8000_0000 | r);
        rd(8'h04, 32'h0000_0180);
        bus(8'h28, 1'b1, 32'h4000_0000 | r);
        chk("rx append", {s_rx.valid, s_rx.addr[30:0]}, {1'b1, 11'h000, r});
        park(200);
        rd(8'h04, 32'h0000_0010);
        rd(8'h28, 32'h8000_0000 | r);
        $display("test rx done");
        repeat (2) @(posedge clk_i);
        chk("reads left", expq.size(), 32'h0000_0000);
        summarize();
    end
endmodule

`default_nettype wire
